//--- hw/rb_checker.sv
// Checker end: readback clock source, stream parser and upset alarm
//
// Behaviour
// - Exclusive-OR primary against duplicate output
// - OR all mismatches into one status
// - Status may float the function outputs through O_FUNC_OE
// - Readback clock between 1 and 2 MHz
// - Shift out every flip-flop and configuration bit
// - Append checksum over data after stream
// - Stream routable to pin or internal
// - Readback runs without disturbing user logic
// - Stream starts with five ones, one zero
// - Count size-dependent data bits after preamble
// - Capture checksum from final eleven bits
// - Compare captured checksum with expected value
// - Mismatch raises alarm, later request reconfiguration
// - With user memory verify bit for bit
// - Reconfigure on outside failure or periodically
`timescale 1ns/1ps
module rb_checker #(
  parameter int unsigned DATA_BITS = rb_pkg::DATA_BITS_SMALL,
  parameter logic [31:0] RECONF_PERIOD_CYC = 32'h00000000
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  rb_link_if.checker_end LINK,
  input wire logic I_ENABLE,
  input wire rb_pkg::crc_t I_EXPECTED_CRC,
  input wire logic I_FULL_VERIFY,
  input wire logic I_REF_BIT,
  input wire logic I_ALARM_CLR,
  input wire logic I_CONVENIENT,
  input wire logic I_FAIL_ELSEWHERE,
  output logic [rb_pkg::CNT_W-1:0] O_REF_ADDR,
  output rb_pkg::crc_t O_CRC_CAPTURED,
  output logic O_CHECK_DONE,
  output logic O_UPSET_ALARM,
  output logic O_RECONFIG_REQ
);
  import rb_pkg::*;

  localparam logic [DIV_W-1:0] HALF_M1 = DIV_W'(RB_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
  localparam logic [31:0] TMR_ONE = 32'h00000001;
  localparam logic [31:0] TMR_ZERO = 32'h00000000;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
  localparam logic [31:0] TMR_LAST = RECONF_PERIOD_CYC - TMR_ONE;
  localparam cnt_t DATA_LAST = CNT_W'(DATA_BITS - 1);
  localparam cnt_t CRC_LAST = CNT_W'(CRC_LEN - 1);

  // ==========================================================
  // State
  typedef enum logic [4:0] {
    H_HUNT = 5'h01,
    H_DATA = 5'h02,
    H_GAP = 5'h04,
    H_CRC = 5'h08,
    H_CMP = 5'h10
  } hstate_t;
  typedef struct packed {
    hstate_t state;
    logic [DIV_W-1:0] div;
    logic rb_clk;
    logic rb_start;
    logic line_s1;
    logic line_s2;
    logic [PRE_LEN-1:0] shift;
    cnt_t cnt;
    cnt_t ref_addr;
    crc_t crc_cap;
    logic bad;
    logic done;
    logic alarm;
    logic reconf;
    logic [31:0] timer;
  } chk_t;
  chk_t st, next_st;

  logic sample;
  logic set_alarm;
  logic timer_hit;
  logic crc_bad;
  logic [PRE_LEN-1:0] hunt_next;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    sample = 1'b0;
    set_alarm = 1'b0;
    timer_hit = 1'b0;
    crc_bad = (st.crc_cap != I_EXPECTED_CRC);
    hunt_next = {st.shift[PRE_LEN-2:0], st.line_s2};
    next_st.done = 1'b0;

    // ==========================================================
    // Clock divider, stays inside the allowed band
    next_st.div = st.div + DIV_ONE;
    if (st.div == HALF_M1) begin
      next_st.div = DIV_ZERO;
      next_st.rb_clk = !st.rb_clk;
      if (st.rb_clk) begin
        next_st.rb_start = I_ENABLE;
      end else begin
        sample = 1'b1;
      end
    end

    // ==========================================================
    // Line synchroniser, the line moves with the link clock
    next_st.line_s1 = LINK.rb_line;
    next_st.line_s2 = st.line_s1;

    // ==========================================================
    // Frame parser
    unique case (st.state)
      H_HUNT: begin
        if (sample) begin
          next_st.shift = hunt_next;
          if (hunt_next == PREAMBLE) begin
            next_st.state = H_DATA;
            next_st.cnt = CNT_ZERO;
            next_st.ref_addr = CNT_ZERO;
            next_st.bad = 1'b0;
          end
        end
      end

      H_DATA: begin
        if (sample) begin
          if (I_FULL_VERIFY && (st.line_s2 != I_REF_BIT)) begin
            next_st.bad = 1'b1;
          end
          next_st.ref_addr = st.ref_addr + CNT_ONE;
          next_st.cnt = st.cnt + CNT_ONE;
          if (st.cnt == DATA_LAST) begin
            next_st.state = H_GAP;
          end
        end
      end

      H_GAP: begin
        if (sample) begin
          next_st.cnt = CNT_ZERO;
          next_st.state = H_CRC;
        end
      end

      H_CRC: begin
        if (sample) begin
          next_st.crc_cap = {st.crc_cap[CRC_LEN-2:0], st.line_s2};
          next_st.cnt = st.cnt + CNT_ONE;
          if (st.cnt == CRC_LAST) begin
            next_st.state = H_CMP;
          end
        end
      end

      H_CMP: begin
        next_st.done = 1'b1;
        if (I_FULL_VERIFY) begin
          set_alarm = st.bad;
        end else begin
          set_alarm = crc_bad;
        end
        next_st.shift = '0;
        next_st.state = H_HUNT;
      end
    endcase

    // ==========================================================
    // Sticky alarm, a new event beats the clear
    next_st.alarm = (st.alarm & !I_ALARM_CLR) | set_alarm;

    // ==========================================================
    // Periodic reconfiguration, zero period disables it
    if (RECONF_PERIOD_CYC != TMR_ZERO) begin
      next_st.timer = st.timer + TMR_ONE;
      if (st.timer == TMR_LAST) begin
        next_st.timer = TMR_ZERO;
        timer_hit = 1'b1;
      end
    end

    // ==========================================================
    // Reconfiguration request
    next_st.reconf = (st.alarm & I_CONVENIENT) | I_FAIL_ELSEWHERE | timer_hit;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st <= '{state: H_HUNT, line_s1: 1'b1, line_s2: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign LINK.rb_clk = st.rb_clk;
  assign LINK.rb_start = st.rb_start;
  assign O_REF_ADDR = st.ref_addr;
  assign O_CRC_CAPTURED = st.crc_cap;
  assign O_CHECK_DONE = st.done;
  assign O_UPSET_ALARM = st.alarm;
  assign O_RECONFIG_REQ = st.reconf;
endmodule // rb_checker

//--- hw/rb_device.sv
// Device end: duplicated logic compare and readback stream source
`timescale 1ns/1ps
module rb_device #(
  parameter int unsigned DATA_BITS = rb_pkg::DATA_BITS_SMALL
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  rb_link_if.device_end LINK,
  input wire rb_pkg::func_t I_PRIMARY,
  input wire rb_pkg::func_t I_DUPLICATE,
  input wire logic I_FLOAT_EN,
  input wire logic I_ROUTE_EXT,
  input wire logic I_RB_BIT,
  output logic [rb_pkg::CNT_W-1:0] O_RB_ADDR,
  output logic O_RB_INTERNAL,
  output logic O_UPSET,
  output logic O_FLOAT,
  output rb_pkg::func_t O_FUNC_OUT,
  output logic O_FUNC_OE
);
  import rb_pkg::*;

  // ==========================================================
  // User clock domain
  typedef struct packed {
    logic upset;
    logic float_out;
    func_t func_out;
    logic func_oe;
  } user_t;
  user_t us, next_us;
  logic mism;

  always_comb begin
    mism = |(I_PRIMARY ^ I_DUPLICATE);
    next_us.upset = mism;
    next_us.float_out = mism & I_FLOAT_EN;
    next_us.func_out = I_PRIMARY;
    next_us.func_oe = !(mism & I_FLOAT_EN);
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      us <= '0;
    end else begin
      us <= next_us;
    end
  end

  assign O_UPSET = us.upset;
  assign O_FLOAT = us.float_out;
  assign O_FUNC_OUT = us.func_out;
  assign O_FUNC_OE = us.func_oe;

  // ==========================================================
  // Readback domain, runs beside user logic
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_PRE = 5'h02,
    S_DATA = 5'h04,
    S_GAP = 5'h08,
    S_CRC = 5'h10
  } dstate_t;
  typedef struct packed {
    dstate_t state;
    cnt_t cnt;
    cnt_t addr;
    crc_t crc;
    logic rb_data;
    logic rb_oe;
    logic route_s1;
    logic route_s2;
  } rbk_t;
  rbk_t rs, next_rs;

  always_comb begin
    next_rs = rs;
    next_rs.route_s1 = I_ROUTE_EXT;
    next_rs.route_s2 = rs.route_s1;
    next_rs.rb_oe = rs.route_s2;
    unique case (rs.state)
      S_IDLE: begin
        next_rs.rb_data = 1'b1;
        if (LINK.rb_start) begin
          next_rs.rb_data = PREAMBLE[PRE_LEN-1];
          next_rs.cnt = CNT_ONE;
          next_rs.state = S_PRE;
        end
      end
      S_PRE: begin
        next_rs.rb_data = PREAMBLE[PRE_LEN-1-rs.cnt];
        next_rs.cnt = rs.cnt + CNT_ONE;
        if (rs.cnt == CNT_W'(PRE_LEN - 1)) begin
          next_rs.cnt = CNT_ZERO;
          next_rs.addr = CNT_ZERO;
          next_rs.crc = CRC_INIT;
          next_rs.state = S_DATA;
        end
      end
      S_DATA: begin
        next_rs.rb_data = I_RB_BIT;
        next_rs.crc = {rs.crc[CRC_LEN-2:0], 1'b0}
          ^ ((rs.crc[CRC_LEN-1] ^ I_RB_BIT) ? CRC_POLY : CRC_INIT);
        next_rs.addr = rs.addr + CNT_ONE;
        next_rs.cnt = rs.cnt + CNT_ONE;
        if (rs.cnt == CNT_W'(DATA_BITS - 1)) begin
          next_rs.state = S_GAP;
        end
      end
      S_GAP: begin
        next_rs.rb_data = 1'b0;
        next_rs.cnt = CNT_ZERO;
        next_rs.state = S_CRC;
      end
      S_CRC: begin
        next_rs.rb_data = rs.crc[CRC_LEN-1];
        next_rs.crc = {rs.crc[CRC_LEN-2:0], 1'b0};
        next_rs.cnt = rs.cnt + CNT_ONE;
        if (rs.cnt == CNT_W'(CRC_LEN - 1)) begin
          next_rs.state = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge LINK.rb_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rs <= '{state: S_IDLE, rb_data: 1'b1, default: '0};
    end else begin
      rs <= next_rs;
    end
  end

  assign LINK.rb_data = rs.rb_data;
  assign LINK.rb_oe = rs.rb_oe;
  assign O_RB_INTERNAL = rs.rb_data;
  assign O_RB_ADDR = rs.addr;
endmodule // rb_device

//--- hw/rb_link_if.sv
// Readback serial link between the device and its checker
`timescale 1ns/1ps
interface rb_link_if;
  logic rb_clk;
  logic rb_start;
  logic rb_data;
  logic rb_oe;
  logic rb_line;
  // Undriven line idles high through the pull-up
  assign rb_line = rb_oe ? rb_data : 1'b1;
  modport checker_end (output rb_clk, output rb_start, input rb_line);
  modport device_end (input rb_clk, input rb_start, output rb_data, output rb_oe);
endinterface

//--- hw/rb_pkg.sv
// Shared constants and types for the readback upset checker
package rb_pkg;
  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned RB_CLK_MIN_HZ = 1_000_000;
  localparam int unsigned RB_CLK_MAX_HZ = 2_000_000;
  localparam int unsigned RB_CLK_HZ = 1_500_000;
  localparam int unsigned RB_HALF_CYC = CLK_HZ / (2 * RB_CLK_HZ);
  localparam int unsigned DIV_W = 7;
  // ==========================================================
  // Stream layout
  localparam int unsigned PRE_LEN = 6;
  localparam logic [PRE_LEN-1:0] PREAMBLE = 6'h3E;
  localparam int unsigned CRC_LEN = 11;
  localparam int unsigned DATA_BITS_SMALL = 399_630;
  localparam int unsigned DATA_BITS_MID = 841_350;
  localparam int unsigned DATA_BITS_LARGE = 1_445_502;
  localparam int unsigned CNT_W = 21;
  localparam logic [CRC_LEN-1:0] CRC_POLY = 11'h307;
  localparam logic [CRC_LEN-1:0] CRC_INIT = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;
  // ==========================================================
  // Duplicated logic
  localparam int unsigned NUM_FUNCS = 4;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [CRC_LEN-1:0] crc_t;
  typedef logic [NUM_FUNCS-1:0] func_t;
endpackage

//--- tb/rb_link_properties.sv
// Link stream and readback clock properties
`timescale 1ns/1ps
module rb_link_properties #(
  parameter int unsigned DATA_BITS = 20
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic rb_clk,
  input wire logic rb_start,
  input wire logic rb_data,
  input wire logic rb_oe,
  input wire logic rb_line
);
  import rb_pkg::*;
  localparam cnt_t LAST_POS = cnt_t'(DATA_BITS);
  localparam cnt_t GAP_POS = cnt_t'(DATA_BITS + 1);
  localparam cnt_t END_POS = cnt_t'(DATA_BITS + 12);
  cnt_t pos;
  crc_t crc;
  crc_t cap;
  logic [4:0] hist;
  logic [7:0] gap;
  logic seen;
  // ==========
  // Stream position and checksum
  always_ff @(posedge rb_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pos <= CNT_ZERO;
      crc <= CRC_INIT;
      cap <= CRC_INIT;
      hist <= 5'h00;
    end else begin
      hist <= {hist[3:0], rb_data};
      if (pos == CNT_ZERO) begin
        pos <= rb_data ? CNT_ZERO : CNT_ONE;
        crc <= CRC_INIT;
      end else begin
        pos <= (pos == END_POS) ? CNT_ZERO : pos + CNT_ONE;
      end
      if (pos != CNT_ZERO && pos <= LAST_POS) begin
        crc <= {crc[9:0], 1'b0} ^ ({CRC_LEN{crc[10] ^ rb_data}} & CRC_POLY);
      end
      if (pos > GAP_POS) begin
        cap <= {cap[9:0], rb_data};
      end
    end
  end
  // Cycles between readback clock rises
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gap <= 8'h00;
      seen <= 1'b0;
    end else if ($rose(rb_clk)) begin
      gap <= 8'h01;
      seen <= 1'b1;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  // ==========
  // Properties
  property p_clk_fast; @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(rb_clk) && seen |-> gap >= 8'h3F; endproperty
  a_clk_fast: assert property (p_clk_fast) else $error("link clock too fast");
  property p_clk_slow; @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(rb_clk) && seen |-> gap <= 8'h7D; endproperty
  a_clk_slow: assert property (p_clk_slow) else $error("link clock too slow");
  property p_start; @(posedge I_CLK) disable iff (!I_RST_B)
    $changed(rb_start) |-> !rb_clk; endproperty
  a_start: assert property (p_start) else $error("start moved with clock high");
  property p_data; @(posedge I_CLK) disable iff (!I_RST_B)
    $changed(rb_data) |-> $rose(rb_clk); endproperty
  a_data: assert property (p_data) else $error("bit moved off clock rise");
  property p_oe; @(posedge I_CLK) disable iff (!I_RST_B)
    $changed(rb_oe) |-> $rose(rb_clk); endproperty
  a_oe: assert property (p_oe) else $error("route moved off clock rise");
  property p_pre; @(posedge rb_clk) disable iff (!I_RST_B)
    pos == CNT_ZERO && !rb_data |-> hist == 5'h1F; endproperty
  a_pre: assert property (p_pre) else $error("bad preamble");
  property p_gap; @(posedge rb_clk) disable iff (!I_RST_B)
    pos == GAP_POS |-> !rb_data; endproperty
  a_gap: assert property (p_gap) else $error("gap bit not zero");
  property p_crc; @(posedge rb_clk) disable iff (!I_RST_B)
    pos == END_POS |-> {cap[9:0], rb_data} == crc; endproperty
  a_crc: assert property (p_crc) else $error("checksum wrong");
  c_frame: cover property (@(posedge rb_clk) disable iff (!I_RST_B) pos == END_POS);
  c_start: cover property (@(posedge I_CLK) disable iff (!I_RST_B) $rose(rb_start));
  c_internal: cover property (@(posedge I_CLK) disable iff (!I_RST_B) !rb_oe && rb_line);
endmodule // rb_link_properties

//--- tb/readback_crc_upset_checker_tb_top.sv
// Both link ends joined, driven and checked
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, ex, ac); end end
module readback_crc_upset_checker_tb_top;
  import rb_pkg::*;
  localparam int unsigned DB = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  func_t prim = 4'h0;
  func_t dup = 4'h0;
  logic float_en = 1'b0;
  logic route = 1'b1;
  logic flip = 1'b0;
  logic verify = 1'b0;
  logic clr = 1'b0;
  logic conv = 1'b0;
  logic fail = 1'b0;
  crc_t exp_crc = 11'h000;
  cnt_t rb_addr;
  cnt_t ref_addr;
  crc_t crc_seen;
  func_t func_o;
  logic upset, float_o, internal, done, alarm, req, func_oe;
  int err_total = 0;
  int compares = 0;
  int n;
  int lows;
  rb_link_if link ();
  always #4 clk = ~clk;
  function automatic logic pat(cnt_t a);
    return a[0] ^ a[2];
  endfunction
  function automatic crc_t good_crc();
    crc_t c;
    c = CRC_INIT;
    for (int k = 0; k < DB; k++) begin
      c = {c[9:0], 1'b0} ^ ({CRC_LEN{c[10] ^ pat(cnt_t'(k))}} & CRC_POLY);
    end
    return c;
  endfunction
  rb_device #(.DATA_BITS(DB)) rb_device_i (.I_CLK(clk), .I_RST_B(rst_b), .LINK(link),
    .I_PRIMARY(prim), .I_DUPLICATE(dup), .I_FLOAT_EN(float_en), .I_ROUTE_EXT(route),
    .I_RB_BIT(pat(rb_addr) ^ (flip && rb_addr == 21'h000005)), .O_RB_ADDR(rb_addr),
    .O_RB_INTERNAL(internal), .O_UPSET(upset), .O_FLOAT(float_o), .O_FUNC_OUT(func_o),
    .O_FUNC_OE(func_oe));
  rb_checker #(.DATA_BITS(DB), .RECONF_PERIOD_CYC(32'h000003E8)) rb_checker_i (.I_CLK(clk),
    .I_RST_B(rst_b), .LINK(link), .I_ENABLE(1'b1), .I_EXPECTED_CRC(exp_crc),
    .I_FULL_VERIFY(verify), .I_REF_BIT(pat(ref_addr)), .I_ALARM_CLR(clr),
    .I_CONVENIENT(conv), .I_FAIL_ELSEWHERE(fail), .O_REF_ADDR(ref_addr),
    .O_CRC_CAPTURED(crc_seen), .O_CHECK_DONE(done), .O_UPSET_ALARM(alarm),
    .O_RECONFIG_REQ(req));
  rb_link_properties #(.DATA_BITS(DB)) rb_link_properties_i (.I_CLK(clk), .I_RST_B(rst_b),
    .rb_clk(link.rb_clk), .rb_start(link.rb_start), .rb_data(link.rb_data),
    .rb_oe(link.rb_oe), .rb_line(link.rb_line));
  // ==========
  // Tasks
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 4000; k++) begin
      step(1);
      if (done === 1'b1) break;
    end
    if (k == 4000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // ==========
  // Scenarios
  initial begin
    exp_crc = good_crc();
    step(1);
    rst_b = 1'b0;
    step(10);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      prim = func_t'(i) ^ 4'hA;
      dup = prim ^ func_t'(4'h1 << i);
      float_en = i[0];
      step(3);
      `CHK("upset", 1'b1, upset)
      `CHK("float", float_en, float_o)
      `CHK("func_oe", ~float_en, func_oe)
      `CHK("func", prim, func_o)
      dup = prim;
      step(3);
      `CHK("upset", 1'b0, upset)
      `CHK("func_oe", 1'b1, func_oe)
    end
    wait_done();
    wait_done();
    `CHK("crc", exp_crc, crc_seen)
    `CHK("alarm", 1'b0, alarm)
    exp_crc = exp_crc ^ 11'h001;
    wait_done();
    `CHK("alarm", 1'b1, alarm)
    exp_crc = good_crc();
    wait_done();
    `CHK("alarm", 1'b1, alarm)
    conv = 1'b1;
    step(2);
    `CHK("reconf", 1'b1, req)
    conv = 1'b0;
    clr = 1'b1;
    step(2);
    clr = 1'b0;
    `CHK("alarm", 1'b0, alarm)
    n = 0;
    repeat (1000) begin
      step(1);
      n += (req === 1'b1);
    end
    `CHK("period", 1, n)
    fail = 1'b1;
    step(2);
    `CHK("reconf", 1'b1, req)
    fail = 1'b0;
    verify = 1'b1;
    exp_crc = ~exp_crc;
    wait_done();
    wait_done();
    `CHK("alarm", 1'b0, alarm)
    flip = 1'b1;
    wait_done();
    wait_done();
    `CHK("alarm", 1'b1, alarm)
    route = 1'b0;
    step(400);
    `CHK("oe", 1'b0, link.rb_oe)
    n = 0;
    lows = 0;
    repeat (3200) begin
      step(1);
      n += (internal === 1'b0);
      lows += (link.rb_line === 1'b0);
    end
    `CHK("internal", 1'b1, n > 0)
    `CHK("line", 0, lows)
    tally_and_finish();
  end
endmodule // readback_crc_upset_checker_tb_top
